// [dv/cpu_core_registers_stack_test.sv]
// Self-checking bench for the CPU register, stack and clock divider block.
// Assumes the command port contract of the block: one command per core enable.
module cpu_core_registers_stack_test;
  timeunit 1ns;
  timeprecision 1ps;
  import cpu_core_pkg::*;

  logic        ref_clk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic        clock_divide_select_i = 1'b0;
  logic        irq_event_i = 1'b0;
  logic [15:0] vector_i = 16'hABC0;
  logic        cmd_valid_i = 1'b0;
  cmd_t        cmd_i = '0;
  logic        cmd_ready_o;
  regs_t       regs_o;
  logic        busy_o;
  logic        irq_pending_o;
  logic        cpu_clk_o;
  logic        usb_clk_o;
  logic        core_en_o;
  int          fail_count = 0;
  int          check_count = 0;

  always #12.5 ref_clk_i = ~ref_clk_i;

  cpu_core_registers_stack uut (
    .ref_clk_i             (ref_clk_i),
    .nrst_i                (nrst_i),
    .clock_divide_select_i (clock_divide_select_i),
    .irq_event_i           (irq_event_i),
    .vector_i              (vector_i),
    .cmd_valid_i           (cmd_valid_i),
    .cmd_i                 (cmd_i),
    .cmd_ready_o           (cmd_ready_o),
    .regs_o                (regs_o),
    .busy_o                (busy_o),
    .irq_pending_o         (irq_pending_o),
    .cpu_clk_o             (cpu_clk_o),
    .usb_clk_o             (usb_clk_o),
    .core_en_o             (core_en_o)
  );

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (exp !== got) begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      fail_count++;
    end
  endtask

  // Ready is combinational, so it is judged mid-cycle, away from the taking edge.
  task automatic issue(input op_t op, input dest_t d, input flag_class_t f,
                       input logic [7:0] data, input logic [1:0] ch, input logic [15:0] addr);
    int k;
    @(posedge ref_clk_i);
    #1;
    cmd_i = '{op: op, dest: d, fl: f, data: data, carry: ch[1], half_carry: ch[0],
              addr: addr, last: 1'b1};
    cmd_valid_i = 1'b1;
    for (k = 0; k < 60; k++) begin
      @(negedge ref_clk_i);
      if (cmd_ready_o === 1'b1) break;
    end
    if (k == 60) begin
      fail_count++;
      stop_test();
    end
    @(posedge ref_clk_i);
    #1 cmd_valid_i = 1'b0;
    @(negedge ref_clk_i);
  endtask

  task automatic wait_busy(input logic lvl);
    int k;
    for (k = 0; k < 200; k++) begin
      @(negedge ref_clk_i);
      if (busy_o === lvl) break;
    end
    if (k == 200) begin
      fail_count++;
      stop_test();
    end
  endtask

  task automatic test_reset();
    chk("flags", 16'h00E8, {8'h00, regs_o.flags});
    chk("sp", 16'h013F, regs_o.sp);
    chk("a x", 16'h0000, {regs_o.a, regs_o.x});
    chk("y", 16'h0000, {8'h00, regs_o.y});
    chk("pc", 16'h0000, regs_o.pc);
  endtask

  task automatic test_flags();
    issue(OP_WRITE, DST_FLAGS, FL_NONE, 8'h00, 2'h0, 16'h0);
    chk("fixed bits", 16'h00E0, {8'h00, regs_o.flags});
    issue(OP_WRITE, DST_A, FL_LOGIC, 8'h80, 2'h0, 16'h0);
    chk("n z", 16'h0004, {14'h0, regs_o.flags[N_BIT], regs_o.flags[Z_BIT]} << 1);
    issue(OP_FLAGS, DST_A, FL_ARITH, 8'h00, 2'h0, 16'h0);
    chk("zero", 16'h0001, {14'h0, regs_o.flags[N_BIT], regs_o.flags[Z_BIT]});
    issue(OP_WRITE, DST_A, FL_ADD, 8'h00, 2'h3, 16'h0);
    chk("h c set", 16'h0003, {14'h0, regs_o.flags[H_BIT], regs_o.flags[C_BIT]});
    issue(OP_WRITE, DST_A, FL_ADD, 8'h01, 2'h0, 16'h0);
    chk("h c clr", 16'h0000, {14'h0, regs_o.flags[H_BIT], regs_o.flags[C_BIT]});
    issue(OP_SET_CARRY, DST_A, FL_NONE, 8'h00, 2'h0, 16'h0);
    chk("carry set", 16'h0001, {15'h0, regs_o.flags[C_BIT]});
    issue(OP_RESET_CARRY, DST_A, FL_NONE, 8'h00, 2'h0, 16'h0);
    chk("carry clr", 16'h0000, {15'h0, regs_o.flags[C_BIT]});
    chk("fixed kept", 16'h0007, {13'h0, regs_o.flags[7:5]});
  endtask

  task automatic test_stack();
    issue(OP_WRITE, DST_A, FL_NONE, 8'h5A, 2'h0, 16'h0);
    issue(OP_PUSH, DST_A, FL_NONE, 8'h00, 2'h0, 16'h0);
    chk("sp push", 16'h013E, regs_o.sp);
    issue(OP_WRITE, DST_A, FL_NONE, 8'h00, 2'h0, 16'h0);
    issue(OP_POP, DST_A, FL_NONE, 8'h00, 2'h0, 16'h0);
    chk("sp pop", 16'h013F, regs_o.sp);
    chk("pop data", 16'h005A, {8'h00, regs_o.a});
    issue(OP_LOAD_SP_LOW, DST_A, FL_NONE, 8'h00, 2'h0, 16'h0);
    chk("sp load", 16'h0100, regs_o.sp);
    issue(OP_PUSH, DST_A, FL_NONE, 8'h00, 2'h0, 16'h0);
    chk("wrap low", 16'h013F, regs_o.sp);
    issue(OP_POP, DST_X, FL_NONE, 8'h00, 2'h0, 16'h0);
    chk("wrap high", 16'h0100, regs_o.sp);
    chk("wrap data", 16'h005A, {8'h00, regs_o.x});
    issue(OP_STACK_RESET, DST_A, FL_NONE, 8'h00, 2'h0, 16'h0);
    chk("sp reset", 16'h013F, regs_o.sp);
  endtask

  task automatic test_irq();
    issue(OP_JUMP, DST_A, FL_NONE, 8'h00, 2'h0, 16'h1234);
    issue(OP_WRITE, DST_X, FL_NONE, 8'h11, 2'h0, 16'h0);
    issue(OP_WRITE, DST_A, FL_NONE, 8'h22, 2'h0, 16'h0);
    issue(OP_WRITE, DST_Y, FL_NONE, 8'h33, 2'h0, 16'h0);
    issue(OP_SET_MASK, DST_A, FL_NONE, 8'h00, 2'h0, 16'h0);
    chk("mask set", 16'h0001, {15'h0, regs_o.flags[I_BIT]});
    @(posedge ref_clk_i);
    #1 irq_event_i = 1'b1;
    @(posedge ref_clk_i);
    #1 irq_event_i = 1'b0;
    repeat (14) @(negedge ref_clk_i);
    chk("pending", 16'h0001, {15'h0, irq_pending_o});
    chk("masked", 16'h0000, {15'h0, busy_o});
    issue(OP_CLEAR_MASK, DST_A, FL_NONE, 8'h00, 2'h0, 16'h0);
    wait_busy(1'b1);
    wait_busy(1'b0);
    chk("vector", vector_i, regs_o.pc);
    chk("frame", 16'h013A, regs_o.sp);
    chk("entry mask", 16'h0001, {15'h0, regs_o.flags[I_BIT]});
    chk("taken", 16'h0000, {15'h0, irq_pending_o});
    issue(OP_WRITE, DST_A, FL_NONE, 8'h99, 2'h0, 16'h0);
    issue(OP_WRITE, DST_X, FL_NONE, 8'h77, 2'h0, 16'h0);
    issue(OP_INTERRUPT_RETURN, DST_A, FL_NONE, 8'h00, 2'h0, 16'h0);
    wait_busy(1'b1);
    wait_busy(1'b0);
    chk("ret pc", 16'h1234, regs_o.pc);
    chk("ret sp", 16'h013F, regs_o.sp);
    chk("ret a x", 16'h2211, {regs_o.a, regs_o.x});
    chk("ret mask", 16'h0000, {15'h0, regs_o.flags[I_BIT]});
    chk("y kept", 16'h0033, {8'h00, regs_o.y});
    chk("ret fixed", 16'h0007, {13'h0, regs_o.flags[7:5]});
  endtask

  // A call leaves a two byte frame; a trap enters even with the mask set.
  task automatic test_call_trap();
    issue(OP_JUMP, DST_A, FL_NONE, 8'h00, 2'h0, 16'h2468);
    issue(OP_CALL, DST_A, FL_NONE, 8'h00, 2'h0, 16'h4000);
    wait_busy(1'b0);
    chk("call pc", 16'h4000, regs_o.pc);
    chk("call frame", 16'h013D, regs_o.sp);
    issue(OP_RETURN, DST_A, FL_NONE, 8'h00, 2'h0, 16'h0);
    wait_busy(1'b0);
    chk("return pc", 16'h2468, regs_o.pc);
    chk("return sp", 16'h013F, regs_o.sp);
    issue(OP_SET_MASK, DST_A, FL_NONE, 8'h00, 2'h0, 16'h0);
    issue(OP_TRAP, DST_A, FL_NONE, 8'h00, 2'h0, 16'h5000);
    wait_busy(1'b0);
    chk("trap pc", 16'h5000, regs_o.pc);
    chk("trap frame", 16'h013A, regs_o.sp);
    issue(OP_INTERRUPT_RETURN, DST_A, FL_NONE, 8'h00, 2'h0, 16'h0);
    wait_busy(1'b0);
    chk("trap ret pc", 16'h2468, regs_o.pc);
    chk("trap ret mask", 16'h0000, {15'h0, regs_o.flags[I_BIT]});
  endtask

  // Counts how many reference cycles one clock output stays at a level.
  task automatic run_len(input logic usb, input logic lvl, output int n);
    int k;
    n = 0;
    for (k = 0; k < 40 && (usb ? usb_clk_o : cpu_clk_o) === lvl; k++) @(negedge ref_clk_i);
    for (k = 0; k < 40 && (usb ? usb_clk_o : cpu_clk_o) !== lvl; k++) @(negedge ref_clk_i);
    for (k = 0; k < 40 && (usb ? usb_clk_o : cpu_clk_o) === lvl; k++) begin
      n++;
      @(negedge ref_clk_i);
    end
  endtask

  task automatic test_clocks();
    int n;
    int k;
    // The enable pulse stands in the low cycle just before the core clock rises.
    for (k = 0; k < 12 && core_en_o !== 1'b1; k++) @(negedge ref_clk_i);
    chk("core en", 16'h0001, {15'h0, core_en_o});
    chk("cpu before en", 16'h0000, {15'h0, cpu_clk_o});
    @(negedge ref_clk_i);
    chk("cpu after en", 16'h0002, {14'h0, cpu_clk_o, core_en_o});
    run_len(1'b0, 1'b1, n);
    chk("cpu high", 16'h0003, n[15:0]);
    run_len(1'b0, 1'b0, n);
    chk("cpu low", 16'h0003, n[15:0]);
    run_len(1'b1, 1'b1, n);
    chk("usb half slow", 16'h0004, n[15:0]);
    @(posedge ref_clk_i);
    #1 clock_divide_select_i = 1'b1;
    repeat (16) @(negedge ref_clk_i);
    run_len(1'b1, 1'b0, n);
    chk("usb half fast", 16'h0002, n[15:0]);
    run_len(1'b0, 1'b1, n);
    chk("cpu kept", 16'h0003, n[15:0]);
  endtask

  initial begin
    repeat (12) @(posedge ref_clk_i);
    #1 nrst_i = 1'b1;
    @(negedge ref_clk_i);
    test_reset();
    test_flags();
    test_stack();
    test_irq();
    test_call_trap();
    test_clocks();
    stop_test();
  end
endmodule

// [rtl/cpu_core_pkg.sv]
// Shared constants and carriers for the CPU register and stack block.
// Assumes one reference clock running at twice the oscillator rate.
package cpu_core_pkg;
  // Flag register layout and reset pattern; don't-care reset bits chosen as zero.
  localparam logic [7:0] FLAGS_RESET = 8'hE8;
  localparam logic [7:0] FLAGS_FIXED = 8'hE0;
  localparam int         H_BIT       = 4;
  localparam int         I_BIT       = 3;
  localparam int         N_BIT       = 2;
  localparam int         Z_BIT       = 1;
  localparam int         C_BIT       = 0;
  // Stack pointer: upper ten bits fixed, low six bits count.
  localparam logic [15:0] SP_RESET    = 16'h013F;
  localparam logic [9:0]  SP_FIXED    = SP_RESET[15:6];
  localparam logic [5:0]  SP_LOW_INIT = SP_RESET[5:0];
  localparam int          STACK_DEPTH = 64;
  // Frame sizes in bytes.
  localparam logic [2:0] INT_FRAME_BYTES  = 3'h5;
  localparam logic [2:0] CALL_FRAME_BYTES = 3'h2;
  // Divider terminal counts in reference cycles per half period of the output.
  // One reference cycle is half an oscillator period, so the core divides by 3,
  // USB by 4 normally or by 2 with the divide select set.
  localparam logic [1:0] CORE_HALF_LAST     = 2'h2;
  localparam logic [1:0] USB_HALF_LAST_SLOW = 2'h3;
  localparam logic [1:0] USB_HALF_LAST_FAST = 2'h1;

  typedef enum logic [3:0] {
    OP_NOP, OP_WRITE, OP_FLAGS, OP_SET_CARRY, OP_RESET_CARRY, OP_SET_MASK,
    OP_CLEAR_MASK, OP_LOAD_SP_LOW, OP_STACK_RESET, OP_PUSH, OP_POP, OP_JUMP,
    OP_CALL, OP_RETURN, OP_TRAP, OP_INTERRUPT_RETURN
  } op_t;
  typedef enum logic [1:0] {DST_A, DST_X, DST_Y, DST_FLAGS} dest_t;
  typedef enum logic [2:0] {FL_NONE, FL_LOGIC, FL_ARITH, FL_ADD, FL_CARRY_ONLY} flag_class_t;

  typedef struct packed {
    op_t         op;
    dest_t       dest;
    flag_class_t fl;
    logic [7:0]  data;
    logic        carry;
    logic        half_carry;
    logic [15:0] addr;
    logic        last;
  } cmd_t;

  typedef struct packed {
    logic [7:0]  a;
    logic [7:0]  x;
    logic [7:0]  y;
    logic [7:0]  flags;
    logic [15:0] pc;
    logic [15:0] sp;
  } regs_t;
endpackage

// [rtl/cpu_core_registers_stack.sv]
// Programmer-visible registers, 64-byte wrapping stack and clock dividers.
// Assumes the instruction sequencer issues one command per core clock enable
// and treats every input but nrst_i as synchronous to ref_clk_i.

// Function
// [RULE_01] Flag register holds fixed ones and five flags
// [RULE_02] Add operations update half carry from bit 3
// [RULE_03] Mask set on entry, blocks all but trap
// [RULE_04] Masked requests stay pending, taken when cleared
// [RULE_05] Negative flag copies result bit 7
// [RULE_06] Zero flag set on zero result
// [RULE_07] Carry from arithmetic, set/reset, shifts, bit tests
// [RULE_08] Stack pointer: decrement after push, increment before pop
// [RULE_09] Upper ten bits fixed; reset to top
// [RULE_10] Stack wraps silently both directions
// [RULE_11] PC low saved first; frames five or two
// [RULE_12] Entry at boundary saves PC, X, A, flags
// [RULE_13] Interrupt return restores context, clears mask
// [RULE_14] Second index register never saved automatically
// [RULE_15] Program counter is sixteen bits, two bytes
// [RULE_16] Load instruction writes stack pointer low byte
// [RULE_17] One accumulator and two index registers
// [RULE_18] Core clock oscillator/3, USB oscillator/2 or /4
// [RULE_19] Divide select keeps USB clock with slow oscillator
// [RULE_20] Core clock is 50% square wave
// [RULE_21] Fixed flag bits ignore writes, read ones
module cpu_core_registers_stack (
  // Clock and reset
  input  wire logic                 ref_clk_i,
  input  wire logic                 nrst_i,
  // Configuration and events
  input  wire logic                 clock_divide_select_i,
  input  wire logic                 irq_event_i,
  input  wire logic [15:0]          vector_i,
  // Command port
  input  wire logic                 cmd_valid_i,
  input  wire cpu_core_pkg::cmd_t   cmd_i,
  output logic                      cmd_ready_o,
  // Register view and status
  output cpu_core_pkg::regs_t       regs_o,
  output logic                      busy_o,
  output logic                      irq_pending_o,
  // Clocks
  output logic                      cpu_clk_o,
  output logic                      usb_clk_o,
  output logic                      core_en_o
);
  import cpu_core_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_SAVE, ST_RESTORE} state_t;

  logic                 rst_s1_r;
  logic                 rst_n;
  logic [1:0]           core_cnt_r, core_cnt_nxt, usb_cnt_r, usb_cnt_nxt, usb_last;
  logic                 cpu_clk_r, cpu_clk_nxt, usb_clk_r, usb_clk_nxt, core_en;
  logic [7:0]           a_r, a_nxt, x_r, x_nxt, y_r, y_nxt, flags_r, flags_nxt;
  logic [15:0]          pc_r, pc_nxt, target_r, target_nxt;
  logic [5:0]           sp_r, sp_nxt, pop_addr;
  state_t               state_r, state_nxt;
  logic [2:0]           step_r, step_nxt, frame_last, idx;
  logic                 irq_frame_r, irq_frame_nxt, pending_r, pending_nxt;
  logic                 boundary_r, boundary_nxt, take, accept, mem_we, upd_en;
  logic [7:0]           mem_wdata, pop_byte;
  logic [7:0]           stack_mem [STACK_DEPTH];

  // Release of the asynchronous reset is retimed through two flops.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_s1_r <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n    <= rst_s1_r;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n);

  function automatic logic [1:0] div_step(input logic [1:0] cnt, input logic [1:0] last);
    return (cnt == last) ? 2'h0 : cnt + 2'h1;
  endfunction

  function automatic logic [7:0] upd_flags(input logic [7:0] f, input cmd_t c);
    logic [7:0] r;
    r = f;
    // [RULE_05] [RULE_06] N and Z from result
    if (c.fl inside {FL_LOGIC, FL_ARITH, FL_ADD}) begin
      r[N_BIT] = c.data[7];
      r[Z_BIT] = (c.data == 8'h00);
    end
    // [RULE_07] carry from arithmetic, shift, bit test
    if (c.fl inside {FL_ARITH, FL_ADD, FL_CARRY_ONLY}) r[C_BIT] = c.carry;
    // [RULE_02] half carry on add
    if (c.fl == FL_ADD) r[H_BIT] = c.half_carry;
    return r;
  endfunction

  // [RULE_18] [RULE_19] [RULE_20] toggle dividers
  // Each output toggles after a whole half period, so duty is exact; the
  // enable marks the rising edge of the core clock.
  always_comb begin
    usb_last     = clock_divide_select_i ? USB_HALF_LAST_FAST : USB_HALF_LAST_SLOW;
    core_cnt_nxt = div_step(core_cnt_r, CORE_HALF_LAST);
    usb_cnt_nxt  = div_step(usb_cnt_r, usb_last);
    cpu_clk_nxt  = (core_cnt_r == CORE_HALF_LAST) ? ~cpu_clk_r : cpu_clk_r;
    usb_clk_nxt  = (usb_cnt_r == usb_last) ? ~usb_clk_r : usb_clk_r;
    core_en      = (core_cnt_r == CORE_HALF_LAST) && !cpu_clk_r;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      core_cnt_r <= 2'h0;
      usb_cnt_r  <= 2'h0;
      cpu_clk_r  <= 1'b0;
      usb_clk_r  <= 1'b0;
    end else begin
      core_cnt_r <= core_cnt_nxt;
      usb_cnt_r  <= usb_cnt_nxt;
      cpu_clk_r  <= cpu_clk_nxt;
      usb_clk_r  <= usb_clk_nxt;
    end
  end

  assign pop_addr   = sp_r + 6'h01;
  assign pop_byte   = stack_mem[pop_addr];
  assign frame_last = irq_frame_r ? INT_FRAME_BYTES - 3'h1 : CALL_FRAME_BYTES - 3'h1;

  always_comb begin
    a_nxt         = a_r;
    x_nxt         = x_r;
    y_nxt         = y_r;
    flags_nxt     = flags_r;
    pc_nxt        = pc_r;
    sp_nxt        = sp_r;
    state_nxt     = state_r;
    step_nxt      = step_r;
    irq_frame_nxt = irq_frame_r;
    target_nxt    = target_r;
    boundary_nxt  = boundary_r;
    mem_we        = 1'b0;
    mem_wdata     = 8'h00;
    idx           = 3'h0;
    // [RULE_04] pending request taken once mask clear
    take   = core_en && (state_r == ST_IDLE) && boundary_r && pending_r && !flags_r[I_BIT];
    accept = core_en && (state_r == ST_IDLE) && !take && cmd_valid_i;
    // A request arriving while the latch is consumed stays pending.
    pending_nxt = irq_event_i | (pending_r & ~take);
    if (take) begin
      // [RULE_12] entry at instruction boundary
      state_nxt     = ST_SAVE;
      step_nxt      = 3'h0;
      irq_frame_nxt = 1'b1;
      target_nxt    = vector_i;
    end else if (accept) begin
      boundary_nxt = cmd_i.last;
      case (cmd_i.op)
        OP_WRITE: begin
          // [RULE_17] accumulator and index registers
          case (cmd_i.dest)
            DST_A:   a_nxt = cmd_i.data;
            DST_X:   x_nxt = cmd_i.data;
            DST_Y:   y_nxt = cmd_i.data;
            // [RULE_21] fixed bits forced on write
            default: flags_nxt = cmd_i.data | FLAGS_FIXED;
          endcase
          if (cmd_i.dest != DST_FLAGS) flags_nxt = upd_flags(flags_r, cmd_i);
        end
        OP_FLAGS:       flags_nxt = upd_flags(flags_r, cmd_i);
        // [RULE_07] carry set and reset instructions
        OP_SET_CARRY:   flags_nxt[C_BIT] = 1'b1;
        OP_RESET_CARRY: flags_nxt[C_BIT] = 1'b0;
        // [RULE_03] software sets or clears the mask
        OP_SET_MASK:    flags_nxt[I_BIT] = 1'b1;
        OP_CLEAR_MASK:  flags_nxt[I_BIT] = 1'b0;
        // [RULE_16] load into stack pointer low byte
        OP_LOAD_SP_LOW: sp_nxt = cmd_i.data[5:0];
        // [RULE_09] stack reset instruction
        OP_STACK_RESET: sp_nxt = SP_LOW_INIT;
        OP_PUSH: begin
          // [RULE_08] [RULE_10] write then decrement, wrapping
          mem_we = 1'b1;
          case (cmd_i.dest)
            DST_A:   mem_wdata = a_r;
            DST_X:   mem_wdata = x_r;
            DST_Y:   mem_wdata = y_r;
            default: mem_wdata = flags_r;
          endcase
          sp_nxt = sp_r - 6'h01;
        end
        OP_POP: begin
          // [RULE_08] [RULE_10] increment then read, wrapping
          sp_nxt = pop_addr;
          case (cmd_i.dest)
            DST_A:   a_nxt = pop_byte;
            DST_X:   x_nxt = pop_byte;
            DST_Y:   y_nxt = pop_byte;
            default: flags_nxt = pop_byte | FLAGS_FIXED;
          endcase
        end
        OP_JUMP: pc_nxt = cmd_i.addr;
        OP_CALL, OP_TRAP: begin
          // [RULE_03] trap enters regardless of mask
          state_nxt     = ST_SAVE;
          step_nxt      = 3'h0;
          irq_frame_nxt = (cmd_i.op == OP_TRAP);
          target_nxt    = cmd_i.addr;
          boundary_nxt  = 1'b1;
        end
        OP_RETURN, OP_INTERRUPT_RETURN: begin
          state_nxt     = ST_RESTORE;
          step_nxt      = 3'h0;
          irq_frame_nxt = (cmd_i.op == OP_INTERRUPT_RETURN);
          boundary_nxt  = 1'b1;
        end
        default: ;
      endcase
    end else if (core_en && state_r == ST_SAVE) begin
      // [RULE_11] [RULE_14] save PROGRAM_COUNTER_LOW first, PROGRAM_COUNTER_HIGH, X, A, flags; Y untouched
      idx    = step_r;
      mem_we = 1'b1;
      case (idx)
        3'h0:    mem_wdata = pc_r[7:0];
        3'h1:    mem_wdata = pc_r[15:8];
        3'h2:    mem_wdata = x_r;
        3'h3:    mem_wdata = a_r;
        default: mem_wdata = flags_r;
      endcase
      sp_nxt   = sp_r - 6'h01;
      step_nxt = step_r + 3'h1;
      if (step_r == frame_last) begin
        state_nxt = ST_IDLE;
        // [RULE_15] program counter loads target_r: the vector on interrupt entry, the command address on call or trap
        pc_nxt    = target_r;
        // [RULE_03] mask set on interrupt entry
        if (irq_frame_r) flags_nxt[I_BIT] = 1'b1;
      end
    end else if (core_en && state_r == ST_RESTORE) begin
      // [RULE_13] restore in reverse order
      idx    = frame_last - step_r;
      sp_nxt = pop_addr;
      case (idx)
        3'h0:    pc_nxt[7:0]  = pop_byte;
        3'h1:    pc_nxt[15:8] = pop_byte;
        3'h2:    x_nxt        = pop_byte;
        3'h3:    a_nxt        = pop_byte;
        default: flags_nxt    = pop_byte | FLAGS_FIXED;
      endcase
      step_nxt = step_r + 3'h1;
      if (step_r == frame_last) begin
        state_nxt = ST_IDLE;
        if (irq_frame_r) flags_nxt[I_BIT] = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      a_r         <= 8'h00;
      x_r         <= 8'h00;
      y_r         <= 8'h00;
      // [RULE_01] flag reset pattern, mask set
      flags_r     <= FLAGS_RESET;
      pc_r        <= 16'h0000;
      // [RULE_09] stack pointer reset to top
      sp_r        <= SP_LOW_INIT;
      state_r     <= ST_IDLE;
      step_r      <= 3'h0;
      irq_frame_r <= 1'b0;
      target_r    <= 16'h0000;
      pending_r   <= 1'b0;
      boundary_r  <= 1'b1;
    end else begin
      a_r         <= a_nxt;
      x_r         <= x_nxt;
      y_r         <= y_nxt;
      flags_r     <= flags_nxt;
      pc_r        <= pc_nxt;
      sp_r        <= sp_nxt;
      state_r     <= state_nxt;
      step_r      <= step_nxt;
      irq_frame_r <= irq_frame_nxt;
      target_r    <= target_nxt;
      pending_r   <= pending_nxt;
      boundary_r  <= boundary_nxt;
    end
  end

  // Stack contents are not reset; software must not pop what it never pushed.
  always_ff @(posedge ref_clk_i) begin
    if (mem_we) stack_mem[sp_r] <= mem_wdata;
  end

  assign cmd_ready_o   = core_en && (state_r == ST_IDLE) && !take;
  assign busy_o        = (state_r != ST_IDLE);
  assign irq_pending_o = pending_r;
  assign cpu_clk_o     = cpu_clk_r;
  assign usb_clk_o     = usb_clk_r;
  assign core_en_o     = core_en;
  // [RULE_09] upper stack pointer bits forced
  assign regs_o = '{a: a_r, x: x_r, y: y_r, flags: flags_r, pc: pc_r, sp: {SP_FIXED, sp_r}};

  flags_reset_a: assert property ($rose(rst_n) |-> regs_o.flags == FLAGS_RESET) // [RULE_01]
    else $error("flags not at reset pattern");
  fixed_bits_a: assert property (regs_o.flags[7:5] == 3'h7) // [RULE_21]
    else $error("fixed flag bits not ones");
  // Every accepted command that loads flags from its class, whatever register it also writes.
  assign upd_en = accept && (cmd_i.op == OP_FLAGS ||
                             (cmd_i.op == OP_WRITE && cmd_i.dest != DST_FLAGS));

  half_carry_a: assert property (upd_en && cmd_i.fl == FL_ADD // [RULE_02]
    |=> regs_o.flags[H_BIT] == $past(cmd_i.half_carry)) else $error("half carry wrong");
  // The take edge, then five save steps one core enable apart, ends 31 cycles later.
  entry_mask_a: assert property (take |-> ##31 (regs_o.flags[I_BIT] && !busy_o)) // [RULE_03]
    else $error("mask not set after entry");
  pending_take_a: assert property (take |=> state_r == ST_SAVE && step_r == 3'h0) // [RULE_04]
    else $error("pending request not taken");
  negative_a: assert property (upd_en && cmd_i.fl inside {FL_LOGIC, FL_ARITH, FL_ADD} // [RULE_05]
    |=> regs_o.flags[N_BIT] == $past(cmd_i.data[7])) else $error("negative flag wrong");
  zero_a: assert property (upd_en && cmd_i.fl inside {FL_LOGIC, FL_ARITH, FL_ADD} // [RULE_06]
    |=> regs_o.flags[Z_BIT] == ($past(cmd_i.data) == 8'h00)) else $error("zero flag wrong");
  set_carry_a: assert property (accept && cmd_i.op == OP_SET_CARRY |=> regs_o.flags[C_BIT]) // [RULE_07]
    else $error("carry not set");
  push_wrap_a: assert property (accept && cmd_i.op == OP_PUSH // [RULE_10]
    |=> regs_o.sp[5:0] == $past(regs_o.sp[5:0]) - 6'h01) else $error("push pointer wrong");
  sp_upper_a: assert property (regs_o.sp[15:6] == SP_FIXED) // [RULE_09]
    else $error("stack pointer upper bits moved");
  core_period_a: assert property ($rose(cpu_clk_o) |-> ##6 $rose(cpu_clk_o)) // [RULE_18]
    else $error("core clock period wrong");
  core_duty_a: assert property ($rose(cpu_clk_o) |-> cpu_clk_o [*3] ##1 !cpu_clk_o [*3]) // [RULE_20]
    else $error("core clock duty wrong");

  irq_entry_c: cover property (take ##[1:40] (state_r == ST_IDLE));
  interrupt_return_c: cover property (accept && cmd_i.op == OP_INTERRUPT_RETURN);
  trap_masked_c: cover property (accept && cmd_i.op == OP_TRAP && flags_r[I_BIT]);
  stack_wrap_c: cover property (accept && cmd_i.op == OP_PUSH && sp_r == 6'h00);
endmodule
